// ==== fsc_defines.vh ====
// Constants for the flash segment controller
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_MAIN_SEG_BYTES   512
`define FSC_INFO_SEG_BYTES   128
`define FSC_MAIN_SEG_SHIFT   9
`define FSC_INFO_SEG_SHIFT   7
`define FSC_ERASED_BYTE      8'hFF
// Operation codes
`define FSC_OP_WRITE_BYTE    3'h0
`define FSC_OP_WRITE_WORD    3'h1
`define FSC_OP_ERASE_MAIN1   3'h2
`define FSC_OP_ERASE_MAINALL 3'h3
`define FSC_OP_ERASE_INFO1   3'h4
`define FSC_OP_ERASE_ALL     3'h5
// Requesting sources
`define FSC_SRC_CPU          2'h0
`define FSC_SRC_JTAG         2'h1
`define FSC_SRC_BOOT         2'h2
`endif

// ==== fsc_array_mem.v ====
// Byte-wide flash array storage with registered read data
`timescale 1ns/1ps
module fsc_array_mem #(
    parameter AW = 13
) (
    // Clock
    input  wire          ref_clk,
    // Port
    input  wire          wrEn,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wrData,
    output reg  [7:0]    rdData
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end
endmodule

// ==== fsc_flash_segment_controller.v ====
// Flash segment controller: byte/word program and segment erase sequencer
`timescale 1ns/1ps
`include "fsc_defines.vh"
// Functional notes
// (RULE1) Accept requests from JTAG, bootloader, processor
// (RULE2) Program one byte or one word per write
// (RULE3) Main segments are 512 bytes each
// (RULE4) Two info segments, A and B, 128 bytes
// (RULE5) Erase all main, or one main segment
// (RULE6) Erase info individually or with all main
// (RULE7) Software erases info memory before first use
// (RULE8) Erase sets ones; program only clears bits
module fsc_flash_segment_controller #(
    parameter MAIN_SEGS = 16
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // Request
    input  wire        reqValid,
    input  wire [1:0]  reqSrc,
    input  wire [2:0]  reqOp,
    input  wire        reqInfo,
    input  wire [13:0] reqAddr,
    input  wire [15:0] reqData,
    // Read port
    input  wire        rdValid,
    input  wire        rdInfo,
    input  wire [13:0] rdAddr,
    // Answer
    output reg         busy,
    output reg         done,
    output reg         reqError,
    output reg  [1:0]  doneSrc,
    output reg         rdDone,
    output reg  [7:0]  rdData
);
    // Array layout: main bytes first, info A and B after them
    localparam MAIN_BYTES = MAIN_SEGS * `FSC_MAIN_SEG_BYTES;
    localparam TOT_BYTES  = MAIN_BYTES + 2 * `FSC_INFO_SEG_BYTES;
    localparam AW         = $clog2(TOT_BYTES);

    localparam ST_IDLE  = 2'h0;
    localparam ST_PROG  = 2'h1;
    localparam ST_ERASE = 2'h2;
    localparam ST_READ  = 2'h3;

    reg  [1:0]    state;
    reg  [AW-1:0] ptr;
    reg  [AW-1:0] lastPtr;
    reg  [15:0]   wdata;
    reg           word;
    reg           second;
    reg  [AW-1:0] memAddr;
    reg           memWe;
    reg  [7:0]    memWd;
    wire [7:0]    memRd;

    // Physical address of a request in the shared array
    function [AW-1:0] physAddr;
        input          info;
        input [13:0]   a;
        begin
            if (info) begin
                physAddr = MAIN_BYTES[AW-1:0] + {{(AW-8){1'b0}}, a[7:0]}; // see (RULE4)
            end else begin
                physAddr = a[AW-1:0];
            end
        end
    endfunction

    wire [AW-1:0] reqPhys = physAddr(reqInfo, reqAddr);
    wire          srcOk   = (reqSrc == `FSC_SRC_CPU) || (reqSrc == `FSC_SRC_JTAG)
                            || (reqSrc == `FSC_SRC_BOOT); // see (RULE1)
    wire          addrOk  = reqInfo ? (reqAddr[13:8] == 6'h00)
                                    : ({1'b0, reqAddr} < MAIN_BYTES);

    fsc_array_mem #(
        .AW (AW)
    ) uMem (
        .ref_clk (ref_clk),
        .wrEn    (memWe),
        .addr    (memAddr),
        .wrData  (memWd),
        .rdData  (memRd)
    );

    // Programming is read-modify-write so bits can only fall to zero
    always @* begin
        memAddr = ptr;
        memWe   = 1'b0;
        memWd   = `FSC_ERASED_BYTE;
        if (state == ST_ERASE) begin
            memWe = 1'b1; // see (RULE8)
        end else if (state == ST_PROG && second) begin
            memWe = 1'b1;
            memWd = memRd & wdata[7:0]; // see (RULE8)
        end else if (state == ST_IDLE) begin
            memAddr = rdValid ? physAddr(rdInfo, rdAddr) : reqPhys;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            ptr      <= {AW{1'b0}};
            lastPtr  <= {AW{1'b0}};
            wdata    <= 16'h0000;
            word     <= 1'b0;
            second   <= 1'b0;
            busy     <= 1'b0;
            done     <= 1'b0;
            reqError <= 1'b0;
            doneSrc  <= 2'h0;
            rdDone   <= 1'b0;
            rdData   <= 8'h00;
        end else begin
            done     <= 1'b0;
            reqError <= 1'b0;
            rdDone   <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (rdValid) begin
                        state <= ST_READ;
                        busy  <= 1'b1;
                    end else if (reqValid) begin
                        doneSrc <= reqSrc;
                        second  <= 1'b0;
                        wdata   <= reqData;
                        if (!srcOk || !addrOk) begin
                            reqError <= 1'b1;
                            done     <= 1'b1;
                        end else begin
                            busy <= 1'b1;
                            case (reqOp)
                                `FSC_OP_WRITE_BYTE, `FSC_OP_WRITE_WORD: begin
                                    // Word writes go to an even address, low byte first
                                    word  <= (reqOp == `FSC_OP_WRITE_WORD); // see (RULE2)
                                    ptr   <= (reqOp == `FSC_OP_WRITE_WORD)
                                             ? {reqPhys[AW-1:1], 1'b0} : reqPhys;
                                    state <= ST_PROG;
                                end
                                `FSC_OP_ERASE_MAIN1: begin
                                    ptr     <= {reqPhys[AW-1:`FSC_MAIN_SEG_SHIFT],
                                                {`FSC_MAIN_SEG_SHIFT{1'b0}}}; // see (RULE3)
                                    lastPtr <= {reqPhys[AW-1:`FSC_MAIN_SEG_SHIFT],
                                                {`FSC_MAIN_SEG_SHIFT{1'b1}}}; // see (RULE5)
                                    state   <= reqInfo ? ST_IDLE : ST_ERASE;
                                    if (reqInfo) begin
                                        reqError <= 1'b1;
                                        done     <= 1'b1;
                                        busy     <= 1'b0;
                                    end
                                end
                                `FSC_OP_ERASE_MAINALL: begin
                                    ptr     <= {AW{1'b0}};
                                    lastPtr <= MAIN_BYTES[AW-1:0] - 1'b1; // see (RULE5)
                                    state   <= ST_ERASE;
                                end
                                `FSC_OP_ERASE_INFO1: begin
                                    ptr     <= {reqPhys[AW-1:`FSC_INFO_SEG_SHIFT],
                                                {`FSC_INFO_SEG_SHIFT{1'b0}}}; // see (RULE6)
                                    lastPtr <= {reqPhys[AW-1:`FSC_INFO_SEG_SHIFT],
                                                {`FSC_INFO_SEG_SHIFT{1'b1}}};
                                    state   <= reqInfo ? ST_ERASE : ST_IDLE;
                                    if (!reqInfo) begin
                                        reqError <= 1'b1;
                                        done     <= 1'b1;
                                        busy     <= 1'b0;
                                    end
                                end
                                `FSC_OP_ERASE_ALL: begin
                                    ptr     <= {AW{1'b0}};
                                    lastPtr <= TOT_BYTES[AW-1:0] - 1'b1; // see (RULE6)
                                    state   <= ST_ERASE;
                                end
                                default: begin
                                    reqError <= 1'b1;
                                    done     <= 1'b1;
                                    busy     <= 1'b0;
                                end
                            endcase
                        end
                    end
                end
                ST_PROG: begin
                    // First cycle fetches the old byte, second merges it
                    if (!second) begin
                        second <= 1'b1;
                    end else if (word) begin
                        word   <= 1'b0;
                        second <= 1'b0;
                        ptr    <= ptr + 1'b1;
                        wdata  <= {8'h00, wdata[15:8]};
                    end else begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end
                end
                ST_ERASE: begin
                    if (ptr == lastPtr) begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end else begin
                        ptr <= ptr + 1'b1;
                    end
                end
                ST_READ: begin
                    rdData <= memRd;
                    rdDone <= 1'b1;
                    busy   <= 1'b0;
                    state  <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== fsc_props.sv ====
// Port checker for the flash segment controller
`timescale 1ns/1ps
module fsc_props #(
    parameter MAIN_SEGS = 16
) (
    input wire        ref_clk,
    input wire        rst,
    input wire        reqValid,
    input wire [1:0]  reqSrc,
    input wire [2:0]  reqOp,
    input wire        reqInfo,
    input wire [13:0] reqAddr,
    input wire        rdValid,
    input wire        busy,
    input wire        done,
    input wire        reqError,
    input wire        rdDone
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire take = reqValid && !busy && !rdValid;
    wire good = take && reqSrc != 2'h3;
    wire inMain = !reqInfo && reqAddr < MAIN_SEGS * 512;
    // Segment erase outlasts any plain delay, so its cycles are counted here
    reg  [9:0] segCnt;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            segCnt <= 10'h000;
        end else if (good && reqOp == 3'h2 && inMain) begin
            segCnt <= 10'h001;
        end else if (segCnt == 10'h201) begin
            segCnt <= 10'h000;
        end else if (segCnt != 10'h000) begin
            segCnt <= segCnt + 10'h001;
        end
    end
    a_bad_source: assert property (take && reqSrc == 2'h3 |=> done && reqError)
        else $error("bad source not refused");
    a_byte_latency: assert property (good && reqOp == 3'h0 && inMain |-> ##3 done && !reqError)
        else $error("byte write latency wrong");
    a_word_latency: assert property (good && reqOp == 3'h1 && inMain |-> ##5 done && !reqError)
        else $error("word write latency wrong");
    a_main_segment: assert property (segCnt != 10'h000 |-> done == (segCnt == 10'h201))
        else $error("main segment erase length wrong");
    a_info_segment: assert property (good && reqOp == 3'h4 && reqInfo && reqAddr < 256 |-> ##129 done)
        else $error("info segment erase length wrong");
    a_bad_opcode: assert property (take && reqOp > 3'h5 |=> reqError)
        else $error("unknown operation accepted");
    a_read_latency: assert property (rdValid && !busy |-> !rdDone ##2 rdDone)
        else $error("read latency wrong");
    a_done_single: assert property (done |-> !busy ##1 !done)
        else $error("done not a single idle pulse");
    c_refused: cover property (done && reqError);
    c_written: cover property (done && !reqError);
    c_read: cover property (rdDone);
endmodule

// ==== fsc_agent.sv ====
// Request agent in place of processor, test port or loader
`timescale 1ns/1ps
module fsc_agent (
    // Clock and status
    input  wire        ref_clk,
    input  wire        done,
    input  wire        reqError,
    input  wire        rdDone,
    input  wire [7:0]  rdData,
    // Requests
    output reg         reqValid = 1'b0,
    output reg  [1:0]  reqSrc = 2'h0,
    output reg  [2:0]  reqOp = 3'h0,
    output reg         reqInfo = 1'b0,
    output reg  [13:0] reqAddr = 14'h0,
    output reg  [15:0] reqData = 16'h0,
    output reg         rdValid = 1'b0,
    output reg         rdInfo = 1'b0,
    output reg  [13:0] rdAddr = 14'h0
);
    // Caller keeps the block idle, so the next edge takes the request
    task req(input [1:0] s, input [2:0] o, input i, input [13:0] a, input [15:0] d,
             output e, output late);
        integer n;
        begin
            @(posedge ref_clk);
            {reqValid, reqSrc, reqOp, reqInfo, reqAddr, reqData} <= {1'b1, s, o, i, a, d};
            @(posedge ref_clk);
            reqValid <= 1'b0;
            // Released lines must not keep looking valid
            {reqAddr, reqData} <= ~{a, d};
            // A refusal pulses done right after the taking edge, so look there first
            #1 n = 0;
            while (!done && n < 3000) begin
                @(posedge ref_clk);
                #1 n = n + 1;
            end
            e = reqError;
            late = !done;
        end
    endtask
    task rd(input i, input [13:0] a, output [7:0] d, output late);
        integer n;
        begin
            @(posedge ref_clk);
            {rdValid, rdInfo, rdAddr} <= {1'b1, i, a};
            @(posedge ref_clk);
            {rdValid, rdAddr} <= {1'b0, ~a};
            n = 0;
            do begin
                @(posedge ref_clk);
                #1 n = n + 1;
            end while (!rdDone && n < 10);
            d = rdData;
            late = !rdDone;
        end
    endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the flash segment controller
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    wire reqValid, reqInfo, rdValid, rdInfo, busy, done, reqError, rdDone;
    wire [1:0] reqSrc, doneSrc;
    wire [2:0] reqOp;
    wire [13:0] reqAddr, rdAddr;
    wire [15:0] reqData;
    wire [7:0] rdData;
    integer errors = 0;
    integer check_count = 0;
    fsc_flash_segment_controller #(.MAIN_SEGS(2)) i_fsc_flash_segment_controller (.*);
    fsc_agent i_fsc_agent (.*);
    initial forever #50 ref_clk = ~ref_clk;
    task end_of_test;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task op(input [1:0] s, input [2:0] o, input i, input [13:0] a, input [15:0] d, input x);
        reg e, late;
        begin
            i_fsc_agent.req(s, o, i, a, d, e, late);
            if (late) begin
                errors = errors + 1;
                end_of_test;
            end
            chk(e, x);
            chk(busy, 8'h0);
        end
    endtask
    task rdc(input i, input [13:0] a, input [7:0] x);
        reg [7:0] d;
        reg late;
        begin
            i_fsc_agent.rd(i, a, d, late);
            if (late) begin
                errors = errors + 1;
                end_of_test;
            end
            chk(d, x);
        end
    endtask
    task t_erase_all;
        begin
            op(2'h0, 3'h5, 1'b0, 14'h0, 16'h0, 1'b0);
            rdc(1'b0, 14'h0, 8'hFF);
            rdc(1'b0, 14'h3FF, 8'hFF);
            rdc(1'b1, 14'hFF, 8'hFF);
            $display("erase all done");
        end
    endtask
    task t_program;
        begin
            op(2'h1, 3'h0, 1'b0, 14'h200, 16'h00A5, 1'b0);
            chk(doneSrc, 8'h1);
            rdc(1'b0, 14'h200, 8'hA5);
            op(2'h0, 3'h0, 1'b0, 14'h200, 16'h000F, 1'b0);
            rdc(1'b0, 14'h200, 8'h05);
            op(2'h2, 3'h1, 1'b0, 14'h3, 16'h1234, 1'b0);
            chk(doneSrc, 8'h2);
            rdc(1'b0, 14'h2, 8'h34);
            rdc(1'b0, 14'h3, 8'h12);
            $display("program done");
        end
    endtask
    task t_segments;
        begin
            op(2'h0, 3'h2, 1'b0, 14'h258, 16'h0, 1'b0);
            rdc(1'b0, 14'h200, 8'hFF);
            rdc(1'b0, 14'h2, 8'h34);
            op(2'h0, 3'h0, 1'b1, 14'h0, 16'h0, 1'b0);
            op(2'h0, 3'h0, 1'b1, 14'h80, 16'h0, 1'b0);
            op(2'h0, 3'h4, 1'b1, 14'h5, 16'h0, 1'b0);
            rdc(1'b1, 14'h0, 8'hFF);
            rdc(1'b1, 14'h80, 8'h00);
            op(2'h0, 3'h3, 1'b0, 14'h0, 16'h0, 1'b0);
            rdc(1'b0, 14'h2, 8'hFF);
            rdc(1'b1, 14'h80, 8'h00);
            $display("segments done");
        end
    endtask
    task t_refuse;
        begin
            op(2'h3, 3'h0, 1'b0, 14'h0, 16'h0, 1'b1);
            op(2'h0, 3'h7, 1'b0, 14'h0, 16'h0, 1'b1);
            op(2'h0, 3'h2, 1'b1, 14'h0, 16'h0, 1'b1);
            op(2'h0, 3'h0, 1'b0, 14'h400, 16'h0, 1'b1);
            op(2'h0, 3'h4, 1'b0, 14'h0, 16'h0, 1'b1);
            op(2'h0, 3'h0, 1'b1, 14'h100, 16'h0, 1'b1);
            rdc(1'b0, 14'h0, 8'hFF);
            $display("refuse done");
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_erase_all;
        t_program;
        t_segments;
        t_refuse;
        end_of_test;
    end
endmodule
bind fsc_flash_segment_controller fsc_props #(.MAIN_SEGS(MAIN_SEGS)) i_fsc_props (.*);
